// ---- dv/cli_detector_chk.sv ----
// checker: port-level assertions for the cold load / inrush detector
module cli_detector_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // inputs
  input wire logic meas_valid,
  input wire cli_pkg::cli_phase_s [cli_pkg::NPH-1:0] primary_phase_currents,
  input wire cli_pkg::cli_cfg_s cfg,
  input wire logic inrush_block_en,
  // outputs
  input wire logic cold_load_out,
  input wire logic inrush_out,
  input wire logic cold_load_block,
  input wire logic inrush_block,
  input wire logic cfg_error
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // strobe verdicts; products widened so the percent test cannot wrap
  logic hi;
  logic lo;
  logic hm;
  logic [6:0] pct_c;
  always_comb begin
    hi = 1'b0;
    lo = 1'b1;
    hm = 1'b0;
    // thresholds above the range act as the top of the range
    pct_c = (cfg.harm_pct > cli_pkg::PCT_MAX) ? cli_pkg::PCT_MAX : cfg.harm_pct;
    for (int i = 0; i < cli_pkg::NPH; i++) begin
      hi |= primary_phase_currents[i].fund > cfg.start_current;
      lo &= primary_phase_currents[i].fund < cfg.pickup_current;
      hm |= 32'(primary_phase_currents[i].harm2) * 100 > 32'(primary_phase_currents[i].fund) * 32'(pct_c);
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ====
  // assertions
  a_block_mirror: assert property (cold_load_block == cold_load_out) else $error("block copy differs");
  a_rise_on_strobe: assert property ($rose(cold_load_out) |-> $past(meas_valid) && $past(hi))
    else $error("rise without start strobe");
  a_inrush_needs_cold: assert property (inrush_out |-> cold_load_out) else $error("inrush alone");
  a_zero_pct_same: assert property (cfg.harm_pct == 0 |-> inrush_out == cold_load_out)
    else $error("zero threshold differs");
  a_block_on_rise: assert property ($rose(cold_load_out) && inrush_block_en |-> inrush_block)
    else $error("no early block");
  a_release_no_harm: assert property (meas_valid && cold_load_out && !hm && cfg.harm_pct != 0 |=> !inrush_block && !inrush_out)
    else $error("block kept without harmonic");
  a_pickup_end: assert property (meas_valid && cold_load_out && lo |=> !cold_load_out) else $error("no drop");
  a_cfg_range: assert property (cfg_error == (cfg.max_time < cli_pkg::MAXT_MIN || cfg.max_time > cli_pkg::MAXT_MAX
    || cfg.harm_pct > cli_pkg::PCT_MAX)) else $error("range flag wrong");
  a_reset_quiet: assert property (disable iff (1'b0) $rose(reset_n) |-> !cold_load_out ##1 !cold_load_out && !inrush_block)
    else $error("output after reset");
  // main scenarios seen
  cover property ($rose(cold_load_out));
  cover property ($rose(inrush_out));
  cover property ($fell(inrush_block) && cold_load_out);
endmodule

bind cli_detector cli_detector_chk u_cli_detector_chk (.mclk(mclk), .reset_n(reset_n), .meas_valid(meas_valid),
  .primary_phase_currents(primary_phase_currents), .cfg(cfg), .inrush_block_en(inrush_block_en),
  .cold_load_out(cold_load_out), .inrush_out(inrush_out), .cold_load_block(cold_load_block),
  .inrush_block(inrush_block), .cfg_error(cfg_error));

// ---- dv/cli_meas_model.sv ----
// partner model: upstream measurement block, one strobe per power cycle
module cli_meas_model (
  // clock
  input wire logic mclk,
  // request from the bench
  input wire logic send,
  input wire cli_pkg::cli_phase_s [cli_pkg::NPH-1:0] data,
  // toward the detector
  output logic meas_valid,
  output cli_pkg::cli_phase_s [cli_pkg::NPH-1:0] phases
);
  timeunit 1ns;
  timeprecision 1ps;
  // between strobes the data shows its inverse, so a stale sample never looks right
  always @(negedge mclk) begin
    meas_valid <= send;
    phases <= send ? data : ~data;
  end
endmodule

// ---- dv/tb_cli_detector.sv ----
// testbench: directed scenarios for the cold load / inrush detector
module tb_cli_detector;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic send = 1'b0;
  logic inrush_block_en = 1'b1;
  cli_pkg::cli_phase_s [cli_pkg::NPH-1:0] data = '0;
  cli_pkg::cli_phase_s [cli_pkg::NPH-1:0] phases;
  cli_pkg::cli_cfg_s cfg = '{16'h0100, 16'h0800, 16'h0200, 15'h0064, 7'h0f};
  logic meas_valid, cold_load_out, inrush_out, cold_load_block, inrush_block, cfg_error;
  int num_errors = 0;
  int checks_done = 0;
  initial forever #10 mclk = ~mclk;
  cli_meas_model u_cli_meas_model (.mclk(mclk), .send(send), .data(data), .meas_valid(meas_valid), .phases(phases));
  cli_detector u_cli_detector (.mclk(mclk), .reset_n(reset_n), .meas_valid(meas_valid),
    .primary_phase_currents(phases), .cfg(cfg), .inrush_block_en(inrush_block_en), .cold_load_out(cold_load_out),
    .inrush_out(inrush_out), .cold_load_block(cold_load_block), .inrush_block(inrush_block), .cfg_error(cfg_error));
  // ====
  // shared tasks
  task automatic check(input string what, input logic seen, input logic exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic do_reset;
    @(negedge mclk);
    reset_n = 1'b0;
    repeat (4) @(negedge mclk);
    reset_n = 1'b1;
    repeat (3) @(negedge mclk);
  endtask
  // phase 0 carries the test current, the other two a fixed level
  task automatic strobe(input logic [15:0] f0, input logic [15:0] h0, input logic [15:0] fo);
    @(negedge mclk);
    send <= 1'b1;
    data <= {{fo, 16'h0000}, {fo, 16'h0000}, {f0, h0}};
    @(negedge mclk);
    send <= 1'b0;
    @(negedge mclk);
  endtask
  // ====
  // scenarios
  task automatic t_cold;
    do_reset();
    strobe(16'h0080, 16'h0000, 16'h0080);
    check("cold armed", cold_load_out, 1'b0);
    strobe(16'h1000, 16'h0000, 16'h0080);
    check("cold on", cold_load_out, 1'b1);
    check("cold block", cold_load_block, 1'b1);
    check("early block", inrush_block, 1'b1);
    check("inrush early", inrush_out, 1'b0);
    strobe(16'h1000, 16'h0400, 16'h0080);
    check("inrush on", inrush_out, 1'b1);
    check("block kept", inrush_block, 1'b1);
    strobe(16'h1000, 16'h0010, 16'h0080);
    check("block freed", inrush_block, 1'b0);
    check("cold held", cold_load_out, 1'b1);
    strobe(16'h0100, 16'h0000, 16'h0080);
    check("cold end", cold_load_out, 1'b0);
    $display("test cold done");
  endtask
  task automatic t_noarm;
    do_reset();
    strobe(16'h1000, 16'h0400, 16'h0080);
    check("unarmed", cold_load_out, 1'b0);
    // arm, then a slow rise through the window before passing start
    strobe(16'h0080, 16'h0000, 16'h0080);
    strobe(16'h0180, 16'h0000, 16'h0080);
    check("rising only", cold_load_out, 1'b0);
    strobe(16'h1000, 16'h0000, 16'h0080);
    check("rise in window", cold_load_out, 1'b1);
    check("rise block", inrush_block, 1'b1);
    strobe(16'h0100, 16'h0000, 16'h0080);
    check("rise end", cold_load_out, 1'b0);
    $display("test unarmed done");
  endtask
  task automatic t_zero;
    cfg.harm_pct = 7'h00;
    inrush_block_en = 1'b0;
    do_reset();
    strobe(16'h0080, 16'h0000, 16'h0080);
    strobe(16'h1000, 16'h0000, 16'h0080);
    check("inrush as cold", inrush_out, 1'b1);
    check("block off", inrush_block, 1'b0);
    $display("test zero done");
  endtask
  task automatic t_cfg;
    logic [14:0] mt [5] = '{15'h0000, 15'h0001, 15'h7530, 15'h7531, 15'h0064};
    logic [6:0] pc [5] = '{7'h0f, 7'h0f, 7'h63, 7'h0f, 7'h64};
    logic ex [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 5; i++) begin
      @(negedge mclk);
      cfg.max_time = mt[i];
      cfg.harm_pct = pc[i];
      #1 check("range flag", cfg_error, ex[i]);
    end
    $display("test range done");
  endtask
  initial begin
    #1000000;
    num_errors++;
    end_of_test();
  end
  initial begin
    t_cold();
    t_noarm();
    t_zero();
    t_cfg();
    end_of_test();
  end
endmodule

// ---- hw/cli_detector.sv ----
// module: cold load pickup and magnetizing inrush detector, top level
//
// Contract
// - Cold load is declared only after all phases sat below idle and one phase then passed start within 80 ms.
// - Cold load detection holds until the maximum time expires or current falls below pickup, whichever is first.
// - Each detection output is offered to both the output routing and the blocking matrix; the code copies only cold load, inrush_block is a separate signal.
// - Inrush detection needs the 80 ms rise condition plus one phase with second harmonic ratio above threshold.
// - A zero harmonic threshold makes inrush detection identical to cold load detection.
// - Inrush blocking asserts at once on the rise condition, before harmonic data of a full cycle exists.
// - After the first full cycle, blocking continues with significant second harmonic and is released otherwise.
// - A rise from idle to start taking longer than 80 ms activates nothing.
// - The maximum time setting spans 0.01 s to 300.00 s in 0.01 s steps.
// - The second harmonic threshold spans 0 to 99 percent of the fundamental.
module cli_detector (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // measurements, one strobe per power-system cycle
  input wire logic meas_valid,
  input wire cli_pkg::cli_phase_s [cli_pkg::NPH-1:0] primary_phase_currents,
  // settings
  input wire cli_pkg::cli_cfg_s cfg,
  input wire logic inrush_block_en,
  // detections toward the output matrix
  output logic cold_load_out,
  output logic inrush_out,
  // detections toward the blocking matrix
  output logic cold_load_block,
  output logic inrush_block,
  // status
  output logic cfg_error
);

  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_n;

  // two-stage release so the whole block leaves reset on one edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================
  // per-phase comparisons
  logic [cli_pkg::NPH-1:0] ph_below_idle;
  logic [cli_pkg::NPH-1:0] ph_above_start;
  logic [cli_pkg::NPH-1:0] ph_above_pickup;
  logic [cli_pkg::NPH-1:0] ph_harm;
  logic [cli_pkg::PCT_W-1:0] pct_eff;

  // ratio test done by cross-multiplying: harm2*100 > pct*fund, no divider needed
  genvar g;
  generate
    for (g = 0; g < cli_pkg::NPH; g++) begin : g_phase
      logic [cli_pkg::MAG_W+6:0] harm_scaled;
      logic [cli_pkg::MAG_W+6:0] fund_scaled;
      assign harm_scaled = (cli_pkg::MAG_W+7)'(primary_phase_currents[g].harm2) * (cli_pkg::MAG_W+7)'(100);
      assign fund_scaled = (cli_pkg::MAG_W+7)'(primary_phase_currents[g].fund) * (cli_pkg::MAG_W+7)'(pct_eff);
      assign ph_below_idle[g] = primary_phase_currents[g].fund < cfg.idle_current_threshold;
      assign ph_above_start[g] = primary_phase_currents[g].fund > cfg.start_current;
      assign ph_above_pickup[g] = primary_phase_currents[g].fund >= cfg.pickup_current;
      assign ph_harm[g] = harm_scaled > fund_scaled;
    end
  endgenerate

  // ==========================================================
  // condition decode
  logic all_idle;
  logic any_start;
  logic any_pickup;
  logic any_harm;
  logic harm_off;
  logic pct_clamped_zero;

  assign all_idle = &ph_below_idle;
  assign any_start = |ph_above_start;
  assign any_pickup = |ph_above_pickup;
  // out of range percentages are clamped to the top of the range
  assign pct_eff = (cfg.harm_pct > cli_pkg::PCT_MAX) ? cli_pkg::PCT_MAX : cfg.harm_pct;
  assign pct_clamped_zero = (pct_eff == 7'h00);
  assign harm_off = pct_clamped_zero;
  assign any_harm = |ph_harm;
  // settings outside their documented ranges are flagged but still run
  assign cfg_error = (cfg.max_time < cli_pkg::MAXT_MIN) || (cfg.max_time > cli_pkg::MAXT_MAX)
                   || (cfg.harm_pct > cli_pkg::PCT_MAX);

  // ==========================================================
  // state machine
  cli_pkg::cli_state_e state;
  cli_pkg::cli_state_e next_state;
  logic win_expired;
  logic time_expired;
  logic win_clear;
  logic time_clear;
  logic rise_hit;
  logic end_hit;

  // window opens on leaving idle and closes on start or 80 ms
  assign rise_hit = (state == cli_pkg::CLI_RISING) && meas_valid && any_start && !win_expired;
  assign end_hit = (state == cli_pkg::CLI_ACTIVE) && (time_expired || (meas_valid && !any_pickup));
  assign win_clear = (state != cli_pkg::CLI_RISING);
  assign time_clear = (state != cli_pkg::CLI_ACTIVE);

  always_comb begin
    next_state = state;
    case (state)
      cli_pkg::CLI_IDLE: begin
        if (meas_valid && all_idle) begin
          next_state = cli_pkg::CLI_ARMED;
        end
      end
      cli_pkg::CLI_ARMED: begin
        if (meas_valid && !all_idle) begin
          next_state = any_start ? cli_pkg::CLI_ACTIVE : cli_pkg::CLI_RISING;
        end
      end
      cli_pkg::CLI_RISING: begin
        if (meas_valid && all_idle) begin
          next_state = cli_pkg::CLI_ARMED;
        end else if (rise_hit) begin
          next_state = cli_pkg::CLI_ACTIVE;
        end else if (win_expired) begin
          next_state = cli_pkg::CLI_IDLE;
        end
      end
      cli_pkg::CLI_ACTIVE: begin
        if (end_hit) begin
          next_state = cli_pkg::CLI_IDLE;
        end
      end
      default: begin
        next_state = cli_pkg::CLI_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= cli_pkg::CLI_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // timers
  cli_ms_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .win_clear(win_clear),
    .time_clear(time_clear),
    .max_time(cfg.max_time),
    .win_expired(win_expired),
    .time_expired(time_expired)
  );

  // ==========================================================
  // inrush tracking
  logic entering;
  logic first_cycle_seen;
  logic harm_latched;

  assign entering = (state != cli_pkg::CLI_ACTIVE) && (next_state == cli_pkg::CLI_ACTIVE);

  // the first strobe after activation is the first full cycle of harmonic data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      first_cycle_seen <= 1'b0;
      harm_latched <= 1'b0;
    end else if (entering || state != cli_pkg::CLI_ACTIVE) begin
      first_cycle_seen <= 1'b0;
      harm_latched <= 1'b0;
    end else if (meas_valid) begin
      first_cycle_seen <= 1'b1;
      harm_latched <= harm_off || any_harm;
    end
  end

  // ==========================================================
  // detection outputs, registered
  logic next_cold;
  logic next_inrush;
  logic next_iblock;
  logic active_next;
  logic strobe_act;
  logic harm_now;
  logic verdict;
  logic seen_any;

  assign active_next = (next_state == cli_pkg::CLI_ACTIVE);
  assign next_cold = active_next;
  // a strobe while active carries a full cycle of harmonic data; the activating strobe does not
  assign strobe_act = (state == cli_pkg::CLI_ACTIVE) && meas_valid;
  assign harm_now = harm_off || any_harm;
  // the newest verdict takes effect on its own strobe, so a release never lags by a cycle
  assign verdict = strobe_act ? harm_now : harm_latched;
  assign seen_any = first_cycle_seen || strobe_act;
  // detection needs the harmonic verdict unless the threshold is zero
  assign next_inrush = active_next && (harm_off || (seen_any && verdict));
  // blocking starts on the rise, before any harmonic verdict exists
  assign next_iblock = inrush_block_en && active_next && (!seen_any || verdict);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cold_load_out <= 1'b0;
      inrush_out <= 1'b0;
      inrush_block <= 1'b0;
    end else begin
      cold_load_out <= next_cold;
      inrush_out <= next_inrush;
      inrush_block <= next_iblock;
    end
  end

  // the same signal feeds both matrices
  assign cold_load_block = cold_load_out;

endmodule

// ---- hw/cli_ms_timer.sv ----
// module: millisecond tick generator with a rise-window counter and a maximum-time counter
module cli_ms_timer (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control
  input wire logic win_clear,
  input wire logic time_clear,
  input wire logic [cli_pkg::MAXT_W-1:0] max_time,
  // status
  output logic win_expired,
  output logic time_expired
);

  logic [15:0] tick_cnt;
  logic [6:0] win_ms;
  logic [3:0] step_ms;
  logic [cli_pkg::MAXT_W-1:0] time_steps;
  logic tick;
  logic step_done;

  // ==========================================================
  // ms tick and step decode
  assign tick = (tick_cnt == 16'(cli_pkg::TICK_CYC - 1));
  assign step_done = tick && (step_ms == 4'(cli_pkg::STEP_MS - 1));
  assign win_expired = (win_ms >= 7'(cli_pkg::RISE_WIN_MS));
  // a setting below the range is treated as the least step
  assign time_expired = (time_steps >= ((max_time < cli_pkg::MAXT_MIN) ? cli_pkg::MAXT_MIN : max_time));

  // free running tick, shared by both counters
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= cli_pkg::TICK_RST;
    end else begin
      tick_cnt <= tick ? cli_pkg::TICK_RST : tick_cnt + 16'h0001;
    end
  end

  // rise window in whole ms; the first tick may be early by under 1 ms
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      win_ms <= cli_pkg::WIN_RST;
    end else if (win_clear) begin
      win_ms <= cli_pkg::WIN_RST;
    end else if (tick && !win_expired) begin
      win_ms <= win_ms + 7'h01;
    end
  end

  // maximum time in 10 ms steps, saturating
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      step_ms <= cli_pkg::STEP_RST;
      time_steps <= cli_pkg::TIME_RST;
    end else if (time_clear) begin
      step_ms <= cli_pkg::STEP_RST;
      time_steps <= cli_pkg::TIME_RST;
    end else if (tick) begin
      step_ms <= step_done ? cli_pkg::STEP_RST : step_ms + 4'h1;
      if (step_done && !time_expired) begin
        time_steps <= time_steps + 15'h0001;
      end
    end
  end

endmodule

// ---- hw/cli_pkg.sv ----
// package: constants, types and settings bundles for the cold load / inrush detector
package cli_pkg;

  // ==========================================================
  // widths
  localparam int MAG_W = 16;            // current magnitude width, per-unit scaled
  localparam int MAXT_W = 15;           // maximum time in 10 ms steps, 1..30000
  localparam int PCT_W = 7;             // harmonic percentage 0..99
  localparam int NPH = 3;

  // ==========================================================
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 1;                               // ms tick period
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;        // cycles per ms tick
  localparam int RISE_WIN_MS = 80;                          // rise window
  localparam int STEP_MS = 10;                              // maximum-time step, 0.01 s
  localparam logic [MAXT_W-1:0] MAXT_MIN = 15'h0001;        // 0.01 s
  localparam logic [MAXT_W-1:0] MAXT_MAX = 15'h7530;        // 300.00 s
  localparam logic [PCT_W-1:0] PCT_MAX = 7'h63;             // 99 %

  // ==========================================================
  // reset values
  localparam logic [15:0] TICK_RST = 16'h0000;
  localparam logic [6:0] WIN_RST = 7'h00;
  localparam logic [3:0] STEP_RST = 4'h0;
  localparam logic [MAXT_W-1:0] TIME_RST = 15'h0000;

  // ==========================================================
  // types
  typedef enum logic [1:0] {CLI_IDLE, CLI_ARMED, CLI_RISING, CLI_ACTIVE} cli_state_e;

  // per-phase measurement from the upstream block
  typedef struct packed {
    logic [MAG_W-1:0] fund;
    logic [MAG_W-1:0] harm2;
  } cli_phase_s;

  // settings bundle
  typedef struct packed {
    logic [MAG_W-1:0] idle_current_threshold;
    logic [MAG_W-1:0] start_current;
    logic [MAG_W-1:0] pickup_current;
    logic [MAXT_W-1:0] max_time;
    logic [PCT_W-1:0] harm_pct;
  } cli_cfg_s;

endpackage
